// ---- design/sprite_cfg.svh ----
// Constants for the sprite channel: word layouts, limits and colour mapping
`ifndef SPRITE_CFG_SVH
`define SPRITE_CFG_SVH

// Register index on the plain register port
`define ADDR_START_POSITION   4'h0
`define ADDR_STOP_CONTROL     4'h1
`define ADDR_POINTER          4'h2
`define ADDR_CHAN_CONTROL     4'h3
`define ADDR_STATUS           4'h4
`define ADDR_BEAM             4'h5

// Control word field positions
`define POS_VERTICAL_START_LINE_LO_HI      15
`define POS_VERTICAL_START_LINE_LO_LO      8
`define POS_HORIZONTAL_START_PIXEL_HI_HI      7
`define POS_HORIZONTAL_START_PIXEL_HI_LO      0
`define CTL_VERTICAL_STOP_LINE_LO_HI       15
`define CTL_VERTICAL_STOP_LINE_LO_LO       8
`define CTL_ATTACH_BIT        7
`define CTL_VERTICAL_START_LINE_MSB        2
`define CTL_VERTICAL_STOP_LINE_MSB         1
`define CTL_HORIZONTAL_START_PIXEL_LSB        0

// Position limits
`define VERTICAL_START_LINE_MAX            9'd262
`define HORIZONTAL_START_PIXEL_MAX            9'd447
`define SPRITE_WIDTH          5'd16

// Colour register mapping: first and last sprite colour registers
`define SPRITE_COLOR_BASE     5'd16
`define SPRITE_COLOR_LAST     5'd31

// Reset values
`define POINTER_RESET         19'h00000
`define CONTROL_RESET         2'h0

`endif

// ---- design/sprite_channel.sv ----
// Sprite channel: structure fetch, position decode and pixel colour selection
// Functional notes
// R1 - Vertical start accepted from line 0 to 262
// R2 - Image is 16 pixels wide, any height
// R3 - Sprite timing always low-res, non-interlaced
// R4 - Two descriptor bits select channel colour register
// R5 - Sprites use colour registers 16 to 31, paired
// R6 - Selector 00 is transparent, first register unused
// R7 - Transparent lets lower priority show through
// R8 - Fetch control, descriptor pairs, end-of-data words
// R9 - Software places structures word aligned
// R10 - Word one: vertical_start_line low, horizontal_start_pixel high bits
// R11 - Word two: vertical_stop_line low, flags, MSBs
// R12 - Height equals stop minus start lines
// R13 - High word bit is selector MSB
// R14 - Low word from lower address first
// R15 - Channel 0 maps 1..3 to 17..19
// R16 - At stop line, next words reload control
// R17 - Start above beam: channel idle this field
// R18 - Pointer advances with every fetched word
// R19 - Horizontal start accepted from 0 to 447
// R20 - Bit 15 is the leftmost pixel
// R21 - Shift starts at horizontal_start_pixel within start..stop
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "sprite_cfg.svh"
module sprite_channel #(
    parameter int CHANNEL = 0
) (
    input  wire logic        CLK_SYS,
    input  wire logic        SRST,
    // Register port
    input  wire logic [3:0]  REG_ADDR,
    input  wire logic [15:0] REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    output logic [15:0]      REG_RDATA,
    // Beam position, low-res pixel pulse and field start
    input  wire logic [8:0]  BEAM_V,
    input  wire logic [8:0]  BEAM_H,
    input  wire logic        PIXEL_EN,
    input  wire logic        LINE_START,
    input  wire logic        FIELD_START,
    // Graphics memory read port
    output logic             MEM_RD,
    output logic [18:0]      MEM_ADDR,
    input  wire logic        MEM_ACK,
    input  wire logic [15:0] MEM_RDATA,
    // Pixel output to priority mixer
    output logic             PIX_OPAQUE,
    output logic [4:0]       PIX_COLOR,
    output logic             ATTACH
);
    sprite_mem_if mif ();

    sprite_pkg::fetch_state_type state_r;
    sprite_pkg::sprite_pos_type  pos_r;
    logic [18:0] ptr_r;
    logic [18:0] ptr_nxt;
    logic        dma_en_r;
    logic        req_r;
    logic        armed_r;
    logic        active_r;
    logic [15:0] data_lo_r;
    logic [15:0] data_hi_r;
    logic [15:0] line_lo_r;
    logic [15:0] line_hi_r;
    logic        line_ready_r;
    logic [15:0] shift_lo_r;
    logic [15:0] shift_hi_r;
    logic [4:0]  shift_cnt_r;
    logic        in_range;
    logic        vertical_start_line_ok;
    logic [1:0]  sel;
    logic [4:0]  color_base;

    // Decoded strobes shared by the fetch concerns
    logic        ptr_wr;
    logic        pos_wr;
    logic        ctl_wr;
    logic        reg_busy;
    logic        take_pos;
    logic        take_ctl;
    logic        take_lo;
    logic        take_hi;
    logic        late_start;
    logic        field_go;
    logic        line_go;
    logic        shift_load;
    logic [15:0] word_src;

    sprite_mem_port u_port (
        .clk       (CLK_SYS),
        .srst      (SRST),
        .mif       (mif),
        .mem_rd    (MEM_RD),
        .mem_addr  (MEM_ADDR),
        .mem_ack   (MEM_ACK),
        .mem_rdata (MEM_RDATA)
    );

    assign mif.req  = req_r;
    assign mif.addr = ptr_r;
    assign ptr_nxt  = ptr_r + 19'd1; // R18

    // Line window: start inclusive, stop exclusive, so height is stop minus start
    assign in_range  = (BEAM_V >= pos_r.vertical_start_line) && (BEAM_V < pos_r.vertical_stop_line); // R12 R21
    assign vertical_start_line_ok = (pos_r.vertical_start_line <= `VERTICAL_START_LINE_MAX); // R1

    // Software control: DMA enable and pointer; pointer takes the written word address, top three bits zero
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            dma_en_r <= 1'b0;
        end else if (REG_WR && REG_ADDR == `ADDR_CHAN_CONTROL) begin
            dma_en_r <= REG_WDATA[0];
        end
    end

    // Position and control writes hold the sequencer for a cycle and a pointer write returns it to idle, so software writes only while the channel idles
    assign ptr_wr   = REG_WR && (REG_ADDR == `ADDR_POINTER);
    assign pos_wr   = REG_WR && (REG_ADDR == `ADDR_START_POSITION);
    assign ctl_wr   = REG_WR && (REG_ADDR == `ADDR_STOP_CONTROL);
    assign reg_busy = ptr_wr || pos_wr || ctl_wr;

    // A returned word counts only in the state that asked for it
    assign take_pos = !reg_busy && mif.valid && (state_r == sprite_pkg::ST_FETCH_POS);
    assign take_ctl = !reg_busy && mif.valid && (state_r == sprite_pkg::ST_FETCH_CTL);
    assign take_lo  = !reg_busy && mif.valid && (state_r == sprite_pkg::ST_FETCH_LO);
    assign take_hi  = !reg_busy && mif.valid && (state_r == sprite_pkg::ST_FETCH_HI);
    // Control fields arrive either from a register write or from a fetched word
    assign word_src   = reg_busy ? REG_WDATA : mif.data;
    // A start above the current beam line ends this field's use
    assign late_start = {mif.data[`CTL_VERTICAL_START_LINE_MSB], pos_r.vertical_start_line[7:0]} < BEAM_V; // R17

    // Fetch triggers: control words at field start, a word pair or a reload per line
    assign field_go = !reg_busy && (state_r == sprite_pkg::ST_IDLE) && dma_en_r && FIELD_START;
    assign line_go  = !reg_busy && (state_r == sprite_pkg::ST_WAIT_LINE) && LINE_START && dma_en_r &&
                      ((BEAM_V == pos_r.vertical_stop_line) || (in_range && vertical_start_line_ok));

    // Fetch sequencer: words consumed in structure order
    always_ff @(posedge CLK_SYS) begin
        if (SRST || ptr_wr) begin
            state_r <= sprite_pkg::ST_IDLE;
        end else if (!reg_busy) begin
            case (state_r)
                sprite_pkg::ST_IDLE: begin
                    if (field_go) begin
                        state_r <= sprite_pkg::ST_FETCH_POS; // R8
                    end
                end
                sprite_pkg::ST_FETCH_POS: begin
                    if (take_pos) begin
                        state_r <= sprite_pkg::ST_FETCH_CTL;
                    end
                end
                sprite_pkg::ST_FETCH_CTL: begin
                    if (take_ctl) begin
                        state_r <= late_start ? sprite_pkg::ST_DONE : sprite_pkg::ST_WAIT_LINE; // R17
                    end
                end
                sprite_pkg::ST_WAIT_LINE: begin
                    // At the stop line the next two words reload control
                    if (line_go && BEAM_V == pos_r.vertical_stop_line) begin
                        state_r <= sprite_pkg::ST_FETCH_POS; // R16
                    end else if (line_go) begin
                        state_r <= sprite_pkg::ST_FETCH_LO;
                    end
                end
                sprite_pkg::ST_FETCH_LO: begin
                    if (take_lo) begin
                        state_r <= sprite_pkg::ST_FETCH_HI;
                    end
                end
                sprite_pkg::ST_FETCH_HI: begin
                    if (take_hi) begin
                        state_r <= sprite_pkg::ST_WAIT_LINE;
                    end
                end
                sprite_pkg::ST_DONE: begin
                    if (FIELD_START) begin
                        state_r <= sprite_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_r <= sprite_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Read request: a one-cycle pulse for every word the sequencer wants next
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            req_r <= 1'b0;
        end else begin
            req_r <= field_go || line_go || take_pos || take_lo;
        end
    end

    // Pointer: loaded by software, then steps once per word taken
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            ptr_r <= `POINTER_RESET;
        end else if (ptr_wr) begin
            ptr_r <= {3'h0, REG_WDATA}; // R9
        end else if (take_pos || take_ctl || take_lo || take_hi) begin
            ptr_r <= ptr_nxt; // R18
        end
    end

    // Decoded position: one field layout for software writes and fetched words
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            pos_r <= '0;
        end else if (pos_wr || take_pos) begin
            pos_r.vertical_start_line[7:0] <= word_src[`POS_VERTICAL_START_LINE_LO_HI:`POS_VERTICAL_START_LINE_LO_LO]; // R10
            pos_r.horizontal_start_pixel[8:1] <= word_src[`POS_HORIZONTAL_START_PIXEL_HI_HI:`POS_HORIZONTAL_START_PIXEL_HI_LO]; // R10
        end else if (ctl_wr || take_ctl) begin
            pos_r.vertical_stop_line[7:0] <= word_src[`CTL_VERTICAL_STOP_LINE_LO_HI:`CTL_VERTICAL_STOP_LINE_LO_LO]; // R11
            pos_r.attach     <= word_src[`CTL_ATTACH_BIT]; // R11
            pos_r.vertical_start_line[8]  <= word_src[`CTL_VERTICAL_START_LINE_MSB]; // R11
            pos_r.vertical_stop_line[8]   <= word_src[`CTL_VERTICAL_STOP_LINE_MSB]; // R11
            pos_r.horizontal_start_pixel[0]  <= word_src[`CTL_HORIZONTAL_START_PIXEL_LSB]; // R11
        end
    end

    // Armed: a new control word arms, a late start disarms for the rest of the field
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            armed_r <= 1'b0;
        end else if (ctl_wr || (take_ctl && !late_start)) begin
            armed_r <= 1'b1;
        end else if (!reg_busy && state_r == sprite_pkg::ST_DONE) begin
            armed_r <= 1'b0; // R17
        end
    end

    // Descriptor words of one line: low word first from the lower address
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            data_lo_r <= 16'h0000;
            data_hi_r <= 16'h0000;
        end else if (take_lo) begin
            data_lo_r <= mif.data; // R14
        end else if (take_hi) begin
            data_hi_r <= mif.data; // R14
        end
    end

    // Line ready: raised when the high word lands; a coincident line start loses
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            line_ready_r <= 1'b0;
        end else if (take_hi) begin
            line_ready_r <= 1'b1;
        end else if (LINE_START) begin
            line_ready_r <= 1'b0;
        end
    end

    // Line data registers: hold last fetched line, so DMA off repeats it
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            line_lo_r <= 16'h0000;
            line_hi_r <= 16'h0000;
        end else if (line_ready_r) begin
            line_lo_r <= data_lo_r;
            line_hi_r <= data_hi_r;
        end
    end

    // Shift load: a line starts at horizontal_start_pixel, counted on the low-res pixel pulse
    assign shift_load = armed_r && in_range && (BEAM_H == pos_r.horizontal_start_pixel) && (pos_r.horizontal_start_pixel <= `HORIZONTAL_START_PIXEL_MAX); // R19 R21

    // Pixel shifters: bit 15 leaves first, whatever the playfield mode
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            shift_lo_r <= 16'h0000;
            shift_hi_r <= 16'h0000;
        end else if (PIXEL_EN && shift_load) begin // R3
            shift_lo_r <= line_lo_r;
            shift_hi_r <= line_hi_r;
        end else if (PIXEL_EN && shift_cnt_r > 5'd1) begin
            shift_lo_r <= {shift_lo_r[14:0], 1'b0}; // R20
            shift_hi_r <= {shift_hi_r[14:0], 1'b0}; // R20
        end
    end

    // Pixel count: sixteen low-res pixels per line, then the channel goes quiet
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            shift_cnt_r <= 5'd0;
            active_r    <= 1'b0;
        end else if (PIXEL_EN && shift_load) begin
            shift_cnt_r <= `SPRITE_WIDTH; // R2
            active_r    <= 1'b1;
        end else if (PIXEL_EN && shift_cnt_r > 5'd1) begin
            shift_cnt_r <= shift_cnt_r - 5'd1;
        end else if (PIXEL_EN) begin
            shift_cnt_r <= 5'd0;
            active_r    <= 1'b0;
        end
    end

    // Selector from bit 15 of each word; high word gives the MSB
    assign sel        = {shift_hi_r[15], shift_lo_r[15]}; // R4 R13
    // Channel pairs share four registers starting at 16
    assign color_base = `SPRITE_COLOR_BASE + 5'(CHANNEL / 2) * 5'd4; // R5 R15

    // Pixel output: 00 is transparent so the mixer shows what lies behind
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            PIX_OPAQUE <= 1'b0;
            PIX_COLOR  <= 5'h00;
        end else begin
            PIX_OPAQUE <= active_r && (sel != 2'b00); // R6 R7
            PIX_COLOR  <= (active_r && sel != 2'b00) ? (color_base | {3'h0, sel}) : 5'h00; // R4 R6 R15
        end
    end

    // Attach flag follows the decoded control word; pairing itself happens in the mixer
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            ATTACH <= 1'b0;
        end else begin
            ATTACH <= pos_r.attach; // R11
        end
    end

    // Register reads: control words are write-only and read as zero
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            REG_RDATA <= 16'h0000;
        end else if (REG_RD) begin
            case (REG_ADDR)
                `ADDR_POINTER:      REG_RDATA <= ptr_r[15:0];
                `ADDR_CHAN_CONTROL: REG_RDATA <= {15'h0000, dma_en_r};
                `ADDR_STATUS:       REG_RDATA <= {10'h000, armed_r, active_r, 1'b0, 3'(state_r)};
                `ADDR_BEAM:         REG_RDATA <= {7'h00, pos_r.vertical_start_line};
                default:            REG_RDATA <= 16'h0000;
            endcase
        end else begin
            REG_RDATA <= 16'h0000;
        end
    end
endmodule : sprite_channel
`default_nettype wire

// ---- design/sprite_mem_if.sv ----
// Word fetch handshake between the fetch engine and the memory port stage
`timescale 1ns/100ps
`default_nettype none
interface sprite_mem_if;
    logic        req;
    logic [18:0] addr;
    logic        valid;
    logic [15:0] data;
    modport engine (output req, output addr, input valid, input data);
    modport port   (input req, input addr, output valid, output data);
endinterface : sprite_mem_if
`default_nettype wire

// ---- design/sprite_mem_port.sv ----
// Registered memory read stage: issues word reads and returns data from a register
`timescale 1ns/100ps
`default_nettype none
module sprite_mem_port (
    input  wire logic        clk,
    input  wire logic        srst,
    sprite_mem_if.port       mif,
    output logic             mem_rd,
    output logic [18:0]      mem_addr,
    input  wire logic        mem_ack,
    input  wire logic [15:0] mem_rdata
);
    logic busy_r;

    // One outstanding read; answer is held in a register for the engine
    always_ff @(posedge clk) begin
        if (srst) begin
            busy_r    <= 1'b0;
            mem_rd    <= 1'b0;
            mem_addr  <= 19'h00000;
            mif.valid <= 1'b0;
            mif.data  <= 16'h0000;
        end else begin
            mif.valid <= 1'b0;
            if (!busy_r && mif.req) begin
                busy_r   <= 1'b1;
                mem_rd   <= 1'b1;
                mem_addr <= mif.addr;
            end else if (busy_r && mem_ack) begin
                busy_r    <= 1'b0;
                mem_rd    <= 1'b0;
                mif.valid <= 1'b1;
                mif.data  <= mem_rdata;
            end
        end
    end
endmodule : sprite_mem_port
`default_nettype wire

// ---- design/sprite_pkg.sv ----
// Types shared by the sprite channel modules
package sprite_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_FETCH_POS,
        ST_FETCH_CTL,
        ST_WAIT_LINE,
        ST_FETCH_LO,
        ST_FETCH_HI,
        ST_DONE
    } fetch_state_type;

    typedef struct packed {
        logic [8:0] vertical_start_line;
        logic [8:0] vertical_stop_line;
        logic [8:0] horizontal_start_pixel;
        logic       attach;
    } sprite_pos_type;

endpackage : sprite_pkg

// ---- dv/sprite_channel_chk.sv ----
// Port-level assertions for one sprite channel
`timescale 1ns/100ps
`default_nettype none
`include "sprite_cfg.svh"
module sprite_channel_chk #(
    parameter int CHANNEL = 0
) (
    input wire logic        CLK_SYS,
    input wire logic        SRST,
    input wire logic [3:0]  REG_ADDR,
    input wire logic [15:0] REG_WDATA,
    input wire logic        REG_WR,
    input wire logic        MEM_RD,
    input wire logic [18:0] MEM_ADDR,
    input wire logic        MEM_ACK,
    input wire logic        PIX_OPAQUE,
    input wire logic [4:0]  PIX_COLOR
);
    localparam logic [4:0] BASE = 5'(16 + 4 * (CHANNEL / 2));
    logic [15:0] next_addr_r;
    logic [4:0]  run_r;

    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (SRST);

    // Next word expected; a pointer write restarts the walk
    always_ff @(posedge CLK_SYS) begin
        if (REG_WR && REG_ADDR == `ADDR_POINTER) begin
            next_addr_r <= REG_WDATA;
        end else if (MEM_RD && MEM_ACK) begin
            next_addr_r <= MEM_ADDR[15:0] + 16'h0001;
        end
    end

    // Run of opaque pixels; saturates so a stuck output still fails
    always_ff @(posedge CLK_SYS) begin
        if (SRST || !PIX_OPAQUE) begin
            run_r <= 5'h00;
        end else if (run_r != 5'h1f) begin
            run_r <= run_r + 5'h01;
        end
    end

    req_hold_a: assert property (MEM_RD && !MEM_ACK |=> MEM_RD)
        else $error("read request dropped before acknowledge");
    addr_hold_a: assert property (MEM_RD && !MEM_ACK |=> $stable(MEM_ADDR))
        else $error("read address moved while waiting");
    ptr_step_a: assert property ($rose(MEM_RD) |-> MEM_ADDR[15:0] == next_addr_r)
        else $error("fetch address skipped or repeated");
    clear_pixel_a: assert property (!PIX_OPAQUE |-> PIX_COLOR == 5'h00)
        else $error("transparent pixel carries a colour");
    color_group_a: assert property (PIX_OPAQUE |-> PIX_COLOR[4:2] == BASE[4:2] && PIX_COLOR[1:0] != 2'b00)
        else $error("colour outside the channel group");
    chan_zero_a: assert property (CHANNEL == 0 && PIX_OPAQUE |-> PIX_COLOR inside {5'h11, 5'h12, 5'h13})
        else $error("channel zero colour not 17 to 19");
    width_limit_a: assert property (PIX_OPAQUE |-> run_r < 5'h10)
        else $error("sprite wider than sixteen pixels");
    quiet_start_a: assert property ($fell(SRST) |-> !MEM_RD && !PIX_OPAQUE ##1 !MEM_RD)
        else $error("activity right after reset");
endmodule : sprite_channel_chk

bind sprite_channel sprite_channel_chk #(.CHANNEL(CHANNEL)) chk_i (
    .CLK_SYS(CLK_SYS), .SRST(SRST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
    .MEM_RD(MEM_RD), .MEM_ADDR(MEM_ADDR), .MEM_ACK(MEM_ACK), .PIX_OPAQUE(PIX_OPAQUE), .PIX_COLOR(PIX_COLOR));
`default_nettype wire

// ---- dv/sprite_channel_test.sv ----
// Self-checking bench for one sprite channel
`timescale 1ns/100ps
`default_nettype none
`include "sprite_cfg.svh"
module sprite_channel_test;
    localparam int VS = 5;
    localparam int VE = 7;
    localparam int HS = 301;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic [3:0]  reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic [8:0]  beam_v = 9'h000;
    logic [8:0]  beam_h = 9'h000;
    logic        pixel_en = 1'b0;
    logic        line_start = 1'b0;
    logic        field_start = 1'b0;
    logic        mem_rd;
    logic [18:0] mem_addr;
    logic        mem_ack;
    logic [15:0] mem_rdata;
    logic        pix_opaque;
    logic [4:0]  pix_color;
    logic        attach;
    logic [3:0]  lat = 4'h0;
    logic [15:0] lo_w [2] = '{16'hc003, 16'h0ff0};
    logic [15:0] hi_w [2] = '{16'ha005, 16'h00ff};
    int          bad_count = 0;
    int          n_tests = 0;

    always #20 clk = ~clk;

    sprite_channel #(.CHANNEL(0)) dut (
        .CLK_SYS(clk), .SRST(srst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
        .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .BEAM_V(beam_v), .BEAM_H(beam_h), .PIXEL_EN(pixel_en),
        .LINE_START(line_start), .FIELD_START(field_start), .MEM_RD(mem_rd), .MEM_ADDR(mem_addr),
        .MEM_ACK(mem_ack), .MEM_RDATA(mem_rdata), .PIX_OPAQUE(pix_opaque), .PIX_COLOR(pix_color),
        .ATTACH(attach));

    sprite_mem_model mem_i (
        .clk(clk), .srst(srst), .lat(lat), .rd(mem_rd), .addr(mem_addr), .ack(mem_ack), .rdata(mem_rdata));

    task automatic report_and_stop();
        if (bad_count == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : reg_read

    // Sweeps one line; pixel for column h shows two edges after h is driven
    task automatic run_line(input int v);
        logic [1:0] sel;
        logic       show;
        int         k;
        @(posedge clk);
        pixel_en <= 1'b0;
        beam_v <= 9'(v);
        beam_h <= 9'h000;
        line_start <= 1'b1;
        @(posedge clk);
        line_start <= 1'b0;
        repeat (20) @(posedge clk);
        for (int i = 0; i < 340; i++) begin
            @(posedge clk);
            pixel_en <= 1'b1;
            beam_h <= 9'(i);
            #1;
            k = i - 2 - HS;
            show = v >= VS && v < VE && k >= 0 && k < 16;
            sel = 2'b00;
            if (show) begin
                sel = {hi_w[v - VS][15 - k], lo_w[v - VS][15 - k]};
            end
            check({15'h0000, pix_opaque}, {15'h0000, sel != 2'b00});
            check({11'h000, pix_color}, sel == 2'b00 ? 16'h0000 : 16'h0010 + 16'(sel));
        end
    endtask : run_line

    // One field from a pointer load; memory answers after l extra cycles
    task automatic run_field(input logic [3:0] l);
        logic [15:0] d;
        lat <= l;
        reg_write(`ADDR_POINTER, 16'h0040);
        reg_write(`ADDR_CHAN_CONTROL, 16'h0001);
        @(posedge clk);
        field_start <= 1'b1;
        beam_v <= 9'h000;
        @(posedge clk);
        field_start <= 1'b0;
        repeat (30) @(posedge clk);
        reg_read(`ADDR_BEAM, d);
        check(d, 16'(VS));
        check({15'h0000, attach}, 16'h0000);
        for (int v = 0; v < 10; v++) begin
            run_line(v);
        end
    endtask : run_field

    initial begin
        logic [15:0] d;
        // Structure on a word boundary: control, two lines, end words
        mem_i.mem[8'h40] = 16'h0596;
        mem_i.mem[8'h41] = 16'h0701;
        mem_i.mem[8'h42] = lo_w[0];
        mem_i.mem[8'h43] = hi_w[0];
        mem_i.mem[8'h44] = lo_w[1];
        mem_i.mem[8'h45] = hi_w[1];
        mem_i.mem[8'h46] = 16'h0000;
        mem_i.mem[8'h47] = 16'h0000;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        reg_write(`ADDR_START_POSITION, 16'h0600);
        reg_write(`ADDR_STOP_CONTROL, 16'h0084);
        reg_read(`ADDR_BEAM, d);
        check(d, 16'h0106);
        check({15'h0000, attach}, 16'h0001);
        reg_read(4'hf, d);
        check(d, 16'h0000);
        run_field(4'h0);
        run_field(4'h3);
        report_and_stop();
    end

    // Cuts a hang well past the expected run of some 7300 cycles
    initial begin
        repeat (30000) @(posedge clk);
        bad_count++;
        report_and_stop();
    end
endmodule : sprite_channel_test
`default_nettype wire

// ---- dv/sprite_mem_model.sv ----
// Behavioural graphics memory answering word reads after a set latency
`timescale 1ns/100ps
`default_nettype none
module sprite_mem_model (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic [3:0]  lat,
    input  wire logic        rd,
    input  wire logic [18:0] addr,
    output logic             ack,
    output logic [15:0]      rdata
);
    logic [15:0] mem [0:255];
    logic [3:0]  wait_r;

    // Data bus toggles between answers so stale words never look valid
    always_ff @(posedge clk) begin
        ack <= 1'b0;
        rdata <= ~rdata;
        if (srst) begin
            wait_r <= 4'h0;
            rdata <= 16'h5a5a;
        end else if (rd && !ack) begin
            if (wait_r == lat) begin
                ack <= 1'b1;
                rdata <= mem[addr[7:0]];
                wait_r <= 4'h0;
            end else begin
                wait_r <= wait_r + 4'h1;
            end
        end
    end
endmodule : sprite_mem_model
`default_nettype wire
